// file: rtl/pcap_top.sv
// peer capability register bank with per-port copies and view select
//
// Summary of operation
// - freeze bit 7 set stops the channel auto-loading any capability field.
// - while frozen, reported values are those software wrote to 0x20 and 0x21.
// - fields load from channel information only after receiver lock is seen.
// - bit 6 is the lowest bit of the three-bit fast channel code.
// - bit 5 asks the serializer to send the frequency training pattern.
// - bit 4 asks the serializer to send the equalizer training pattern.
// - bit 3 reports the peer can run on two lanes.
// - bit 2 on a two-lane peer: 0 primary lane, 1 secondary lane.
// - with second-port view set, reads return the port 1 capabilities.
// - code 000 normal, 001/010/011 fast gpio with 1, 2, 4 gpios.
// - second-port view set routes register accesses to port 1 copies.
`timescale 1ns/10ps
`default_nettype none
module pcap_top
  import pcap_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register access port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // port 0 control channel
  input wire logic p0_rx_lock,
  input wire logic p0_cap_valid,
  input wire logic [6:0] p0_cap_first,
  input wire logic [1:0] p0_code_hi,
  // port 1 control channel
  input wire logic p1_rx_lock,
  input wire logic p1_cap_valid,
  input wire logic [6:0] p1_cap_first,
  input wire logic [1:0] p1_code_hi,
  // port 0 status
  output logic p0_request_freq,
  output logic p0_request_eq,
  output logic p0_two_lane,
  output logic p0_lane_secondary,
  output logic [2:0] p0_gpio_count,
  // port 1 status
  output logic p1_request_freq,
  output logic p1_request_eq,
  output logic p1_two_lane,
  output logic p1_lane_secondary,
  output logic [2:0] p1_gpio_count
);

  // ****************************************
  // register decode
  // ****************************************

  logic [7:0] port_sel_reg;
  logic view1;
  logic wr_first0;
  logic wr_second0;
  logic wr_first1;
  logic wr_second1;
  logic [7:0] first0;
  logic [7:0] first1;
  logic [1:0] second0;
  logic [1:0] second1;
  logic locked0;
  logic locked1;
  logic [7:0] rdata_next;

  assign view1 = port_sel_reg[PCAP_SEL_PORT1_BIT];

  // writes go to the copy of the viewed port only
  assign wr_first0 = reg_wr && (reg_addr == PCAP_ADDR_CAP_FIRST) && !view1;
  assign wr_second0 = reg_wr && (reg_addr == PCAP_ADDR_CAP_SECOND) && !view1;
  assign wr_first1 = reg_wr && (reg_addr == PCAP_ADDR_CAP_FIRST) && view1;
  assign wr_second1 = reg_wr && (reg_addr == PCAP_ADDR_CAP_SECOND) && view1;

  // port select register, low two bits writable, rest read zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_sel_reg <= PCAP_PORT_SEL_RESET;
    end else if (reg_wr && (reg_addr == PCAP_ADDR_PORT_SEL)) begin
      port_sel_reg <= {6'h00, reg_wdata[1:0]};
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rdata_next = PCAP_READ_ZERO;
    case (reg_addr)
      PCAP_ADDR_PORT_SEL: rdata_next = port_sel_reg;
      PCAP_ADDR_CAP_FIRST: rdata_next = view1 ? first1 : first0;
      PCAP_ADDR_CAP_SECOND: rdata_next = {6'h00, (view1 ? second1 : second0)};
      default: rdata_next = PCAP_READ_ZERO;
    endcase
  end

  // read data registered, valid one cycle after the read strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= PCAP_READ_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

  // ****************************************
  // per-port copies
  // ****************************************

  // port 0 copy, fed only by its own channel
  pcap_port_store u_port0 (
    .clk(clk),
    .nrst(nrst),
    .rx_lock(p0_rx_lock),
    .cap_valid(p0_cap_valid),
    .cap_first_in(p0_cap_first),
    .code_hi_in(p0_code_hi),
    .wr_first(wr_first0),
    .wr_second(wr_second0),
    .wdata(reg_wdata),
    .cap_first(first0),
    .cap_second(second0),
    .locked(locked0),
    .request_freq(p0_request_freq),
    .request_eq(p0_request_eq),
    .two_lane(p0_two_lane),
    .lane_secondary(p0_lane_secondary),
    .gpio_count(p0_gpio_count)
  );

  // port 1 copy, fed only by its own channel
  pcap_port_store u_port1 (
    .clk(clk),
    .nrst(nrst),
    .rx_lock(p1_rx_lock),
    .cap_valid(p1_cap_valid),
    .cap_first_in(p1_cap_first),
    .code_hi_in(p1_code_hi),
    .wr_first(wr_first1),
    .wr_second(wr_second1),
    .wdata(reg_wdata),
    .cap_first(first1),
    .cap_second(second1),
    .locked(locked1),
    .request_freq(p1_request_freq),
    .request_eq(p1_request_eq),
    .two_lane(p1_two_lane),
    .lane_secondary(p1_lane_secondary),
    .gpio_count(p1_gpio_count)
  );

  // ****************************************
  // checks
  // ****************************************

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // frozen copy only changes through a software write
  a_freeze_holds_first: assert property (first0[PCAP_FREEZE_BIT] && !wr_first0 |=> $stable(first0))
    else $error("frozen port 0 first register changed");
  a_freeze_holds_second: assert property (first1[PCAP_FREEZE_BIT] && !wr_second1 |=> $stable(second1))
    else $error("frozen port 1 second register changed");

  // software value written with freeze is what is reported
  // the write lands one edge after it is taken, so two idle cycles later it sits two samples back
  a_frozen_write_kept: assert property (wr_first0 && reg_wdata[PCAP_FREEZE_BIT]
    ##1 (!wr_first0)[*2] |-> first0 == $past(reg_wdata, 2))
    else $error("frozen write not kept");

  // no load before lock
  a_no_load_unlocked: assert property (!locked0 && !wr_first0 |=> $stable(first0[6:0]))
    else $error("port 0 loaded without lock");

  // unfrozen locked channel data is taken next cycle
  a_load_takes: assert property (locked1 && p1_cap_valid && !first1[PCAP_FREEZE_BIT] && !wr_first1
    |=> first1[6:0] == $past(p1_cap_first) && second1 == $past(p1_code_hi))
    else $error("port 1 channel data not loaded");

  // code decode follows the stored three bits one cycle later, mapping spelled out apart from the helper
  a_code_decode: assert property (##1 p0_gpio_count == (
    $past({second0, first0[PCAP_CODE0_BIT]} == PCAP_CODE_GPIO1) ? PCAP_COUNT_ONE :
    $past({second0, first0[PCAP_CODE0_BIT]} == PCAP_CODE_GPIO2) ? PCAP_COUNT_TWO :
    $past({second0, first0[PCAP_CODE0_BIT]} == PCAP_CODE_GPIO4) ? PCAP_COUNT_FOUR : PCAP_COUNT_NONE))
    else $error("gpio count mismatch");

  // training requests follow their bits
  a_freq_request: assert property (##1 p0_request_freq == $past(first0[PCAP_FREQ_BIT]))
    else $error("frequency training request mismatch");
  a_eq_request: assert property (##1 p1_request_eq == $past(first1[PCAP_EQ_BIT]))
    else $error("equalizer training request mismatch");

  // lane index only meaningful with two-lane capability
  a_lane_index: assert property (##1 p0_lane_secondary
    == ($past(first0[PCAP_TWO_LANE_BIT]) && $past(first0[PCAP_LANE_BIT])) && p0_two_lane
    == $past(first0[PCAP_TWO_LANE_BIT]))
    else $error("lane index mismatch");

  // read returns the viewed port's copy
  a_view_read: assert property (reg_rd && reg_addr == PCAP_ADDR_CAP_FIRST
    |=> reg_rvalid && reg_rdata == $past(view1 ? first1 : first0))
    else $error("read did not follow view select");

  // port 1 write leaves port 0 untouched
  a_write_routing: assert property (reg_wr && reg_addr == PCAP_ADDR_CAP_FIRST && view1 && !p0_cap_valid
    |=> $stable(first0))
    else $error("write leaked into port 0");

  // main scenarios
  c_auto_load: cover property (locked0 && p0_cap_valid && !first0[PCAP_FREEZE_BIT]);
  c_frozen_load_blocked: cover property (locked1 && p1_cap_valid && first1[PCAP_FREEZE_BIT]);
  c_port1_read: cover property (reg_rd && view1 && reg_addr == PCAP_ADDR_CAP_FIRST);
  c_four_gpio: cover property (p0_gpio_count == PCAP_COUNT_FOUR);

endmodule
`default_nettype wire

// file: rtl/pcap_pkg.sv
// constants and helpers shared by the peer capability register bank
package pcap_pkg;

  // register addresses on the internal register access port
  localparam logic [7:0] PCAP_ADDR_PORT_SEL = 8'h1e;
  localparam logic [7:0] PCAP_ADDR_CAP_FIRST = 8'h20;
  localparam logic [7:0] PCAP_ADDR_CAP_SECOND = 8'h21;

  // reset values
  localparam logic [7:0] PCAP_PORT_SEL_RESET = 8'h01;
  localparam logic [7:0] PCAP_CAP_FIRST_RESET = 8'h00;
  localparam logic [1:0] PCAP_CAP_SECOND_RESET = 2'h0;
  localparam logic [7:0] PCAP_READ_ZERO = 8'h00;

  // field positions in the port select register
  localparam int PCAP_SEL_PORT0_BIT = 0;
  localparam int PCAP_SEL_PORT1_BIT = 1;

  // field positions in the first capability register
  localparam int PCAP_FREEZE_BIT = 7;
  localparam int PCAP_CODE0_BIT = 6;
  localparam int PCAP_FREQ_BIT = 5;
  localparam int PCAP_EQ_BIT = 4;
  localparam int PCAP_TWO_LANE_BIT = 3;
  localparam int PCAP_LANE_BIT = 2;

  // fast control channel codes and their gpio counts
  localparam logic [2:0] PCAP_CODE_NORMAL = 3'h0;
  localparam logic [2:0] PCAP_CODE_GPIO1 = 3'h1;
  localparam logic [2:0] PCAP_CODE_GPIO2 = 3'h2;
  localparam logic [2:0] PCAP_CODE_GPIO4 = 3'h4 - 3'h1;
  localparam logic [2:0] PCAP_COUNT_NONE = 3'h0;
  localparam logic [2:0] PCAP_COUNT_ONE = 3'h1;
  localparam logic [2:0] PCAP_COUNT_TWO = 3'h2;
  localparam logic [2:0] PCAP_COUNT_FOUR = 3'h4;

  // number of fast gpios carried for a three-bit code; normal and reserved give none
  function automatic logic [2:0] pcap_gpio_count(input logic [2:0] code);
    logic [2:0] cnt;
    cnt = PCAP_COUNT_NONE;
    case (code)
      PCAP_CODE_GPIO1: cnt = PCAP_COUNT_ONE;
      PCAP_CODE_GPIO2: cnt = PCAP_COUNT_TWO;
      PCAP_CODE_GPIO4: cnt = PCAP_COUNT_FOUR;
      default: cnt = PCAP_COUNT_NONE;
    endcase
    return cnt;
  endfunction

endpackage

// file: rtl/pcap_port_store.sv
// one port's copy of the peer capability fields with lock sync and auto-load
`timescale 1ns/10ps
`default_nettype none
module pcap_port_store
  import pcap_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control channel side
  input wire logic rx_lock,
  input wire logic cap_valid,
  input wire logic [6:0] cap_first_in,
  input wire logic [1:0] code_hi_in,
  // software side
  input wire logic wr_first,
  input wire logic wr_second,
  input wire logic [7:0] wdata,
  // stored state
  output logic [7:0] cap_first,
  output logic [1:0] cap_second,
  output logic locked,
  // decoded status
  output logic request_freq,
  output logic request_eq,
  output logic two_lane,
  output logic lane_secondary,
  output logic [2:0] gpio_count
);

  logic lock_s1_reg;
  logic lock_s2_reg;
  logic lock_s3_reg;
  logic load;

  // three-stage lock synchroniser, first stage read only by the second
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lock_s1_reg <= 1'b0;
      lock_s2_reg <= 1'b0;
      lock_s3_reg <= 1'b0;
    end else begin
      lock_s1_reg <= rx_lock;
      lock_s2_reg <= lock_s1_reg;
      lock_s3_reg <= lock_s2_reg;
    end
  end

  // lock counts once the last two stages agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      locked <= 1'b0;
    end else if (lock_s2_reg == lock_s3_reg) begin
      locked <= lock_s3_reg;
    end
  end

  // auto-load only after lock and only while not frozen
  assign load = locked && cap_valid && !cap_first[PCAP_FREEZE_BIT];

  // first register: a write that sets freeze wins, otherwise the channel load wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cap_first <= PCAP_CAP_FIRST_RESET;
    end else if (wr_first && wdata[PCAP_FREEZE_BIT]) begin
      cap_first <= wdata;
    end else if (load) begin
      cap_first <= {(wr_first ? wdata[PCAP_FREEZE_BIT] : cap_first[PCAP_FREEZE_BIT]), cap_first_in};
    end else if (wr_first) begin
      cap_first <= wdata;
    end
  end

  // second register holds the two upper code bits
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cap_second <= PCAP_CAP_SECOND_RESET;
    end else if (load && !(wr_first && wdata[PCAP_FREEZE_BIT])) begin
      cap_second <= code_hi_in;
    end else if (wr_second) begin
      cap_second <= wdata[1:0];
    end
  end

  // decoded status, one cycle behind the stored fields
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      request_freq <= 1'b0;
      request_eq <= 1'b0;
      two_lane <= 1'b0;
      lane_secondary <= 1'b0;
      gpio_count <= PCAP_COUNT_NONE;
    end else begin
      request_freq <= cap_first[PCAP_FREQ_BIT];
      request_eq <= cap_first[PCAP_EQ_BIT];
      two_lane <= cap_first[PCAP_TWO_LANE_BIT];
      lane_secondary <= cap_first[PCAP_TWO_LANE_BIT] & cap_first[PCAP_LANE_BIT];
      gpio_count <= pcap_gpio_count({cap_second, cap_first[PCAP_CODE0_BIT]});
    end
  end

endmodule
`default_nettype wire

// file: verif/pcap_peer_model.sv
// remote peer model driving one port's control channel
`timescale 1ns/10ps
`default_nettype none
module pcap_peer_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // commands from the bench
  input wire logic lock_req,
  input wire logic send,
  input wire logic [8:0] cap,
  // control channel toward the block
  output logic rx_lock,
  output logic cap_valid,
  output logic [6:0] cap_first,
  output logic [1:0] code_hi
);
  // fields travel only with valid; otherwise the lines toggle so stale data never looks good
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_lock <= 1'b0;
      cap_valid <= 1'b0;
      {code_hi, cap_first} <= 9'h000;
    end else begin
      rx_lock <= lock_req;
      cap_valid <= send;
      if (send) begin
        {code_hi, cap_first} <= cap;
      end else begin
        {code_hi, cap_first} <= ~{code_hi, cap_first};
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/peer_capability_register_test.sv
// self-checking bench for the peer capability register bank
`timescale 1ns/10ps
`default_nettype none
module peer_capability_register_test;
  import pcap_pkg::*;
  logic clk, nrst, reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, st0, st1;
  logic l0, l1, s0, s1, v0, v1, k0, k1, f0, e0, t0, n0, f1, e1, t1, n1;
  logic [8:0] c0, c1;
  logic [6:0] a0, a1;
  logic [1:0] h0, h1;
  logic [2:0] g0, g1;
  int failures, compares;
  assign st0 = {1'b0, f0, e0, t0, n0, g0};
  assign st1 = {1'b0, f1, e1, t1, n1, g1};
  pcap_peer_model m0 (.clk(clk), .nrst(nrst), .lock_req(l0), .send(s0), .cap(c0),
    .rx_lock(k0), .cap_valid(v0), .cap_first(a0), .code_hi(h0));
  pcap_peer_model m1 (.clk(clk), .nrst(nrst), .lock_req(l1), .send(s1), .cap(c1),
    .rx_lock(k1), .cap_valid(v1), .cap_first(a1), .code_hi(h1));
  pcap_top dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .p0_rx_lock(k0), .p0_cap_valid(v0), .p0_cap_first(a0), .p0_code_hi(h0),
    .p1_rx_lock(k1), .p1_cap_valid(v1), .p1_cap_first(a1), .p1_code_hi(h1),
    .p0_request_freq(f0), .p0_request_eq(e0), .p0_two_lane(t0), .p0_lane_secondary(n0),
    .p0_gpio_count(g0), .p1_request_freq(f1), .p1_request_eq(e1), .p1_two_lane(t1),
    .p1_lane_secondary(n1), .p1_gpio_count(g1));
  // ****************
  // shared tasks
  // ****************
  task automatic final_report();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int i;
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (reg_rvalid !== 1'b1) begin
      failures++;
      final_report();
    end
    d = reg_rdata;
  endtask
  task automatic send(input int p, input logic [8:0] v);
    @(posedge clk);
    if (p == 0) begin
      c0 <= v;
      s0 <= 1'b1;
    end else begin
      c1 <= v;
      s1 <= 1'b1;
    end
    @(posedge clk);
    s0 <= 1'b0;
    s1 <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    logic [7:0] d;
    rd(PCAP_ADDR_CAP_FIRST, d); chk(d, 8'h00);
    rd(PCAP_ADDR_CAP_SECOND, d); chk(d, 8'h00);
    rd(PCAP_ADDR_PORT_SEL, d); chk(d, 8'h01);
    rd(8'h22, d); chk(d, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_load();
    logic [7:0] d;
    send(0, 9'h0ed);
    rd(PCAP_ADDR_CAP_FIRST, d); chk(d, 8'h00);
    @(posedge clk);
    l0 <= 1'b1;
    repeat (8) @(posedge clk);
    send(0, 9'h0ed);
    rd(PCAP_ADDR_CAP_FIRST, d); chk(d, 8'h6d);
    rd(PCAP_ADDR_CAP_SECOND, d); chk(d, 8'h01);
    chk(st0, 8'h5c);
    $display("test load done");
  endtask
  task automatic t_codes();
    logic [7:0] d;
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      send(0, {c[2:1], c[0], 6'h00});
      rd(PCAP_ADDR_CAP_SECOND, d); chk(d, {6'h00, c[2:1]});
      chk(st0, (i == 1) ? 8'h01 : (i == 2) ? 8'h02 : (i == 3) ? 8'h04 : 8'h00);
    end
    $display("test codes done");
  endtask
  task automatic t_freeze();
    logic [7:0] d;
    wr(PCAP_ADDR_CAP_FIRST, 8'h94);
    wr(PCAP_ADDR_CAP_SECOND, 8'h01);
    send(0, 9'h17f);
    rd(PCAP_ADDR_CAP_FIRST, d); chk(d, 8'h94);
    rd(PCAP_ADDR_CAP_SECOND, d); chk(d, 8'h01);
    chk(st0, 8'h22);
    wr(PCAP_ADDR_CAP_FIRST, 8'h30);
    send(0, 9'h048);
    rd(PCAP_ADDR_CAP_FIRST, d); chk(d, 8'h48);
    $display("test freeze done");
  endtask
  task automatic t_view();
    logic [7:0] d;
    @(posedge clk);
    l1 <= 1'b1;
    repeat (8) @(posedge clk);
    send(1, 9'h028);
    chk(st1, 8'h50);
    wr(PCAP_ADDR_PORT_SEL, 8'h02);
    rd(PCAP_ADDR_PORT_SEL, d); chk(d, 8'h02);
    rd(PCAP_ADDR_CAP_FIRST, d); chk(d, 8'h28);
    wr(PCAP_ADDR_CAP_FIRST, 8'h81);
    send(1, 9'h07f);
    rd(PCAP_ADDR_CAP_FIRST, d); chk(d, 8'h81);
    wr(PCAP_ADDR_PORT_SEL, 8'h01);
    rd(PCAP_ADDR_CAP_FIRST, d); chk(d, 8'h48);
    $display("test view done");
  endtask
  // reset in mid-run must bring every copy and status back to idle
  task automatic t_midreset();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    chk(st0, 8'h00);
    chk(st1, 8'h00);
    $display("test midreset done");
  endtask
  // ****************
  // clock, reset and sequence
  // ****************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    nrst = 1'b0;
    {reg_wr, reg_rd, l0, l1, s0, s1} = 6'h00;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    c0 = 9'h000;
    c1 = 9'h000;
    failures = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_load();
    t_codes();
    t_freeze();
    t_view();
    t_midreset();
    final_report();
  end
endmodule
`default_nettype wire
